// File: design/cfg_msg_pkg.sv
// Shared types and constants for the configuration message target
package cfg_msg_pkg;

  // ----------------------------------------------------------------
  // Control token values
  // ----------------------------------------------------------------
  localparam logic [7:0] TOK_WRITE = 8'hc0;
  localparam logic [7:0] TOK_READ = 8'hc1;
  localparam logic [7:0] TOK_PREAD = 8'h25;
  localparam logic [7:0] TOK_ACK = 8'h03;
  localparam logic [7:0] TOK_NACK = 8'h04;
  localparam logic [7:0] TOK_END = 8'h01;

  // ----------------------------------------------------------------
  // Destination patterns and field sizes
  // ----------------------------------------------------------------
  localparam logic [15:0] TILE_DEST_LOW = 16'hc20c;
  localparam logic [15:0] NODE_DEST_LOW = 16'hc30c;
  localparam logic [7:0] PERIPH_DEST_LOW = 8'h02;
  localparam logic [7:0] NO_REPLY_LOW = 8'hff;
  localparam logic [2:0] RET_BYTES = 3'h3;
  localparam logic [2:0] REG_BYTES = 3'h2;
  localparam logic [2:0] PREG_BYTES = 3'h1;
  localparam logic [2:0] DATA_BYTES = 3'h4;

  typedef enum logic [1:0] {
    SP_TILE = 2'h0,
    SP_NODE = 2'h1,
    SP_PERIPH = 2'h2
  } space_t;

  typedef enum logic [1:0] {
    OP_WRITE = 2'h0,
    OP_READ = 2'h1,
    OP_PREAD = 2'h2,
    OP_BAD = 2'h3
  } op_t;

  typedef struct packed {
    logic ctrl;
    logic [7:0] data;
  } tok_t;

  typedef struct packed {
    space_t space;
    logic [7:0] periph;
    logic write;
    logic [15:0] addr;
    logic [31:0] wdata;
  } reg_req_t;

endpackage

// File: design/cfg_msg_target.sv
// Configuration message target: decodes request messages, accesses registers, replies
//
// Summary of operation
// - Return identifier with low byte all ones suppresses the write reply.
// - Multi-byte fields travel most significant byte first.
// - Tile requests arrive at tile identifier followed by c20c.
// - Node requests arrive at node identifier followed by c30c.
// - Peripheral requests arrive at node id, peripheral id, then 02.
// - Write: token 192, return id, 16-bit register, 32-bit data, token 1.
// - Read: token 193, return id, 16-bit register, token 1.
// - Write reply is 3 then 1 on success, 4 then 1 on failure.
// - Read reply is 3, 32-bit data, 1; or 4 then 1.
// - Peripheral read: token 37, return id, 8-bit register, 8-bit size, 1.
// - Peripheral read reply is 3, data bytes, 1; or 4 then 1.
`timescale 1ns/100ps
module cfg_msg_target (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic [15:0] tile_id_i,
  input wire logic [15:0] node_id_i,
  input wire logic rx_valid_i,
  input wire cfg_msg_pkg::tok_t rx_tok_i,
  input wire logic [31:0] rx_dest_i,
  output logic rx_ready_o,
  output logic tx_valid_o,
  output cfg_msg_pkg::tok_t tx_tok_o,
  output logic [23:0] tx_ret_id_o,
  input wire logic tx_ready_i,
  output logic req_valid_o,
  output cfg_msg_pkg::reg_req_t req_o,
  input wire logic ack_i,
  input wire logic ack_ok_i,
  input wire logic [31:0] ack_rdata_i
);

  typedef enum logic [3:0] {
    S_IDLE = 4'h0,
    S_RET = 4'h1,
    S_REG = 4'h2,
    S_SIZE = 4'h3,
    S_WDATA = 4'h4,
    S_END = 4'h5,
    S_DRAIN = 4'h6,
    S_ACC = 4'h7,
    S_WAIT = 4'h8,
    S_HDR = 4'h9,
    S_RDATA = 4'ha,
    S_TAIL = 4'hb
  } state_t;

  // Bytes still to follow the first read byte
  localparam logic [2:0] DATA_LAST = cfg_msg_pkg::DATA_BYTES - 3'h1;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] shift_in(input logic [31:0] acc, input logic [7:0] b);
    shift_in = {acc[23:0], b};
  endfunction

  function automatic cfg_msg_pkg::tok_t ctl(input logic [7:0] v);
    ctl = '{ctrl: 1'b1, data: v};
  endfunction

  function automatic logic rx_state(input state_t s);
    rx_state = (s == S_IDLE) || (s == S_RET) || (s == S_REG) || (s == S_SIZE)
      || (s == S_WDATA) || (s == S_END) || (s == S_DRAIN);
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  state_t state_ff, nxt_state;
  cfg_msg_pkg::op_t op_ff, nxt_op;
  cfg_msg_pkg::space_t space_ff, nxt_space;
  logic [7:0] periph_ff, nxt_periph;
  logic [2:0] cnt_ff, nxt_cnt;
  logic [23:0] ret_ff, nxt_ret;
  logic [15:0] reg_ff, nxt_reg;
  logic [7:0] size_ff, nxt_size;
  logic [31:0] data_ff, nxt_data;
  logic fail_ff, nxt_fail;
  logic drop_ff, nxt_drop;
  logic hdr_sent_ff, nxt_hdr_sent;
  logic rx_ready_ff, nxt_rx_ready;
  logic tx_valid_ff, nxt_tx_valid;
  cfg_msg_pkg::tok_t tx_tok_ff, nxt_tx_tok;
  logic req_valid_ff, nxt_req_valid;
  cfg_msg_pkg::reg_req_t req_ff, nxt_req;

  logic rx_take;
  logic tx_done;
  logic is_tile;
  logic is_node;
  logic is_periph;
  logic is_end;

  assign rx_take = rx_valid_i && rx_ready_ff;
  assign tx_done = tx_valid_ff && tx_ready_i;
  assign is_tile = (rx_dest_i == {tile_id_i, cfg_msg_pkg::TILE_DEST_LOW});
  assign is_node = (rx_dest_i == {node_id_i, cfg_msg_pkg::NODE_DEST_LOW});
  assign is_periph = (rx_dest_i[31:16] == node_id_i)
    && (rx_dest_i[7:0] == cfg_msg_pkg::PERIPH_DEST_LOW);
  assign is_end = rx_tok_i.ctrl && (rx_tok_i.data == cfg_msg_pkg::TOK_END);

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_state = state_ff;
    nxt_op = op_ff;
    nxt_space = space_ff;
    nxt_periph = periph_ff;
    nxt_cnt = cnt_ff;
    nxt_ret = ret_ff;
    nxt_reg = reg_ff;
    nxt_size = size_ff;
    nxt_data = data_ff;
    nxt_fail = fail_ff;
    nxt_drop = drop_ff;
    nxt_hdr_sent = hdr_sent_ff;
    nxt_tx_valid = tx_valid_ff && !tx_ready_i;
    nxt_tx_tok = tx_tok_ff;
    nxt_req_valid = 1'b0;
    nxt_req = req_ff;
    // Reply entry, used where the message or access has finished
    case (state_ff)
      S_IDLE:
      begin
        if (rx_take)
        begin
          nxt_fail = 1'b0;
          nxt_drop = 1'b0;
          nxt_hdr_sent = 1'b0;
          nxt_cnt = cfg_msg_pkg::RET_BYTES;
          nxt_periph = rx_dest_i[15:8];
          nxt_space = is_periph ? cfg_msg_pkg::SP_PERIPH : (is_node ? cfg_msg_pkg::SP_NODE : cfg_msg_pkg::SP_TILE);
          if (!(is_tile || is_node || is_periph))
          begin
            nxt_drop = 1'b1;
            nxt_state = is_end ? S_IDLE : S_DRAIN;
          end
          else
          begin
            nxt_state = is_end ? S_HDR : S_RET;
            if (rx_tok_i.ctrl && rx_tok_i.data == cfg_msg_pkg::TOK_WRITE && !is_periph)
              nxt_op = cfg_msg_pkg::OP_WRITE;
            else if (rx_tok_i.ctrl && rx_tok_i.data == cfg_msg_pkg::TOK_READ && !is_periph)
              nxt_op = cfg_msg_pkg::OP_READ;
            else if (rx_tok_i.ctrl && rx_tok_i.data == cfg_msg_pkg::TOK_PREAD && is_periph)
              nxt_op = cfg_msg_pkg::OP_PREAD;
            else
            begin
              nxt_op = cfg_msg_pkg::OP_BAD;
              nxt_fail = 1'b1;
            end
          end
        end
      end
      S_RET, S_REG, S_SIZE, S_WDATA:
      begin
        if (rx_take)
        begin
          if (rx_tok_i.ctrl)
          begin
            nxt_fail = 1'b1;
            nxt_state = is_end ? S_HDR : S_DRAIN;
          end
          else
          begin
            nxt_cnt = cnt_ff - 3'h1;
            if (state_ff == S_RET)
              nxt_ret = {ret_ff[15:0], rx_tok_i.data};
            else if (state_ff == S_REG)
              nxt_reg = {reg_ff[7:0], rx_tok_i.data};
            else if (state_ff == S_SIZE)
              nxt_size = rx_tok_i.data;
            else
              nxt_data = shift_in(data_ff, rx_tok_i.data);
            if (cnt_ff == 3'h1)
            begin
              case (state_ff)
                S_RET:
                begin
                  nxt_state = fail_ff ? S_DRAIN : S_REG;
                  nxt_reg = 16'h0000;
                  nxt_cnt = (op_ff == cfg_msg_pkg::OP_PREAD) ? cfg_msg_pkg::PREG_BYTES : cfg_msg_pkg::REG_BYTES;
                end
                S_REG:
                begin
                  nxt_cnt = (op_ff == cfg_msg_pkg::OP_WRITE) ? cfg_msg_pkg::DATA_BYTES : 3'h1;
                  nxt_state = (op_ff == cfg_msg_pkg::OP_WRITE) ? S_WDATA
                    : ((op_ff == cfg_msg_pkg::OP_PREAD) ? S_SIZE : S_END);
                end
                default:
                  nxt_state = S_END;
              endcase
            end
          end
        end
      end
      S_END:
      begin
        if (rx_take)
        begin
          if (is_end)
            nxt_state = (op_ff == cfg_msg_pkg::OP_PREAD && size_ff == 8'h00) ? S_HDR : S_ACC;
          else
          begin
            nxt_fail = 1'b1;
            nxt_state = S_DRAIN;
          end
        end
      end
      S_DRAIN:
      begin
        if (rx_take && is_end)
          nxt_state = drop_ff ? S_IDLE : S_HDR;
      end
      S_ACC:
      begin
        nxt_req_valid = 1'b1;
        nxt_req = '{space: space_ff, periph: periph_ff, write: (op_ff == cfg_msg_pkg::OP_WRITE),
                    addr: reg_ff, wdata: data_ff};
        nxt_state = S_WAIT;
      end
      S_WAIT:
      begin
        if (ack_i)
        begin
          nxt_data = ack_rdata_i;
          // Marks that at least one access was made
          nxt_cnt = 3'h1;
          if (op_ff == cfg_msg_pkg::OP_PREAD)
          begin
            nxt_size = size_ff - 8'h01;
            // Peripheral register numbers are one byte and wrap
            nxt_reg = {8'h00, reg_ff[7:0] + 8'h01};
          end
          if (!ack_ok_i && !hdr_sent_ff)
          begin
            nxt_fail = 1'b1;
            nxt_state = S_HDR;
          end
          else if (!ack_ok_i)
          begin
            nxt_tx_valid = 1'b1;
            nxt_tx_tok = ctl(cfg_msg_pkg::TOK_END);
            nxt_state = S_TAIL;
          end
          else if (hdr_sent_ff)
          begin
            nxt_tx_valid = 1'b1;
            nxt_tx_tok = '{ctrl: 1'b0, data: ack_rdata_i[7:0]};
            nxt_state = S_RDATA;
          end
          else
            nxt_state = S_HDR;
        end
      end
      S_HDR:
      begin
        if (!hdr_sent_ff)
        begin
          if (op_ff == cfg_msg_pkg::OP_WRITE && ret_ff[7:0] == cfg_msg_pkg::NO_REPLY_LOW)
            nxt_state = S_IDLE;
          else
          begin
            nxt_hdr_sent = 1'b1;
            nxt_tx_valid = 1'b1;
            nxt_tx_tok = ctl(fail_ff ? cfg_msg_pkg::TOK_NACK : cfg_msg_pkg::TOK_ACK);
          end
        end
        else if (tx_done)
        begin
          nxt_tx_valid = 1'b1;
          nxt_cnt = DATA_LAST;
          if (fail_ff || op_ff == cfg_msg_pkg::OP_WRITE)
          begin
            nxt_tx_tok = ctl(cfg_msg_pkg::TOK_END);
            nxt_state = S_TAIL;
          end
          else if (op_ff == cfg_msg_pkg::OP_READ)
          begin
            nxt_tx_tok = '{ctrl: 1'b0, data: data_ff[31:24]};
            nxt_state = S_RDATA;
          end
          // Size zero: no access was made, close at once
          else if (cnt_ff == 3'h0)
          begin
            nxt_tx_tok = ctl(cfg_msg_pkg::TOK_END);
            nxt_state = S_TAIL;
          end
          else
          begin
            nxt_tx_tok = '{ctrl: 1'b0, data: data_ff[7:0]};
            nxt_state = S_RDATA;
          end
        end
      end
      S_RDATA:
      begin
        if (tx_done)
        begin
          if (op_ff == cfg_msg_pkg::OP_READ && cnt_ff != 3'h0)
          begin
            nxt_cnt = cnt_ff - 3'h1;
            nxt_data = shift_in(data_ff, 8'h00);
            nxt_tx_valid = 1'b1;
            nxt_tx_tok = '{ctrl: 1'b0, data: data_ff[23:16]};
          end
          else if (op_ff == cfg_msg_pkg::OP_PREAD && size_ff != 8'h00)
            nxt_state = S_ACC;
          else
          begin
            nxt_tx_valid = 1'b1;
            nxt_tx_tok = ctl(cfg_msg_pkg::TOK_END);
            nxt_state = S_TAIL;
          end
        end
      end
      S_TAIL:
      begin
        if (tx_done)
          nxt_state = S_IDLE;
      end
      default:
        nxt_state = S_IDLE;
    endcase
    nxt_rx_ready = rx_state(nxt_state);
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_i)
  begin
    if (!resetn_i)
    begin
      state_ff <= S_IDLE;
      op_ff <= cfg_msg_pkg::OP_BAD;
      space_ff <= cfg_msg_pkg::SP_TILE;
      periph_ff <= 8'h00;
      cnt_ff <= 3'h0;
      ret_ff <= 24'h000000;
      reg_ff <= 16'h0000;
      size_ff <= 8'h00;
      data_ff <= 32'h0000_0000;
      fail_ff <= 1'b0;
      drop_ff <= 1'b0;
      hdr_sent_ff <= 1'b0;
      rx_ready_ff <= 1'b0;
      tx_valid_ff <= 1'b0;
      tx_tok_ff <= '0;
      req_valid_ff <= 1'b0;
      req_ff <= '0;
    end
    else
    begin
      state_ff <= nxt_state;
      op_ff <= nxt_op;
      space_ff <= nxt_space;
      periph_ff <= nxt_periph;
      cnt_ff <= nxt_cnt;
      ret_ff <= nxt_ret;
      reg_ff <= nxt_reg;
      size_ff <= nxt_size;
      data_ff <= nxt_data;
      fail_ff <= nxt_fail;
      drop_ff <= nxt_drop;
      hdr_sent_ff <= nxt_hdr_sent;
      rx_ready_ff <= nxt_rx_ready;
      tx_valid_ff <= nxt_tx_valid;
      tx_tok_ff <= nxt_tx_tok;
      req_valid_ff <= nxt_req_valid;
      req_ff <= nxt_req;
    end
  end

  assign rx_ready_o = rx_ready_ff;
  assign tx_valid_o = tx_valid_ff;
  assign tx_tok_o = tx_tok_ff;
  assign tx_ret_id_o = ret_ff;
  assign req_valid_o = req_valid_ff;
  assign req_o = req_ff;

endmodule

// File: verif/cfg_msg_target_properties.sv
// Concurrent checks on the configuration message target ports
`timescale 1ns/100ps
module cfg_msg_target_properties (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic rx_valid_i,
  input wire cfg_msg_pkg::tok_t rx_tok_i,
  input wire logic rx_ready_o,
  input wire logic tx_valid_o,
  input wire cfg_msg_pkg::tok_t tx_tok_o,
  input wire logic [23:0] tx_ret_id_o,
  input wire logic tx_ready_i,
  input wire logic req_valid_o,
  input wire cfg_msg_pkg::reg_req_t req_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!resetn_i);
  wire end_in = rx_valid_i && rx_ready_o && rx_tok_i == 9'h101;
  wire tx_take = tx_valid_o && tx_ready_i;

  a_end_closes: assert property (end_in |=> !rx_ready_o)
    else $error("input still open after closing token");
  a_end_acts: assert property (end_in |-> ##[2:8] (req_valid_o || tx_valid_o))
    else $error("message end left without access or reply");
  a_tx_holds: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_tok_o)
    && $stable(tx_ret_id_o))
    else $error("reply token changed before acceptance");
  a_nack_end: assert property (tx_take && tx_tok_o == 9'h104 |=> tx_valid_o && tx_tok_o == 9'h101)
    else $error("failure token not followed by end token");
  a_reply_ends: assert property (tx_take && tx_tok_o == 9'h101 |=> !tx_valid_o)
    else $error("reply continues after end token");
  a_req_pulse: assert property (req_valid_o |=> !req_valid_o)
    else $error("register request longer than one cycle");
  a_req_stands: assert property (!req_valid_o |-> $stable(req_o))
    else $error("request fields moved without a request");
  a_busy_quiet: assert property (req_valid_o || tx_valid_o |-> !rx_ready_o)
    else $error("tokens accepted during access or reply");
  a_tok_code: assert property (tx_valid_o && tx_tok_o.ctrl |-> tx_tok_o.data inside {8'h01, 8'h03, 8'h04})
    else $error("unexpected control token in reply");

  c_write_req: cover property (req_valid_o && req_o.write);
  c_nack: cover property (tx_valid_o && tx_tok_o == 9'h104);
  c_stall: cover property (tx_valid_o && !tx_ready_i);
endmodule

bind cfg_msg_target cfg_msg_target_properties u_cfg_msg_target_properties (
  .ref_clk_i(ref_clk_i),
  .resetn_i(resetn_i),
  .rx_valid_i(rx_valid_i),
  .rx_tok_i(rx_tok_i),
  .rx_ready_o(rx_ready_o),
  .tx_valid_o(tx_valid_o),
  .tx_tok_o(tx_tok_o),
  .tx_ret_id_o(tx_ret_id_o),
  .tx_ready_i(tx_ready_i),
  .req_valid_o(req_valid_o),
  .req_o(req_o)
);

// File: verif/reply_sink.sv
// Reply receiving side of the requesting channel-end, with stalls
`timescale 1ns/100ps
module reply_sink (
  input wire logic ref_clk_i,
  input wire logic tx_valid_i,
  input wire cfg_msg_pkg::tok_t tx_tok_i,
  input wire logic [31:0] stall_i,
  output logic tx_ready_o
);
  cfg_msg_pkg::tok_t got[$];
  initial tx_ready_o = 1'b0;
  always @(negedge ref_clk_i)
    tx_ready_o <= stall_i[1:0] != 2'h0;
  always @(posedge ref_clk_i)
    if (tx_valid_i && tx_ready_o)
      got.push_back(tx_tok_i);
endmodule

// File: verif/tb.sv
// Self-checking bench for the configuration message target
`timescale 1ns/100ps
module tb;
  logic ref_clk_i, resetn_i, rx_valid_i, rx_ready_o, tx_valid_o, tx_ready_i, req_valid_o;
  logic ack_i = 1'b0;
  logic ack_ok_i = 1'b0;
  logic [15:0] tile_id_i, node_id_i, exp_addr;
  logic [31:0] rx_dest_i, rng, exp_wd;
  logic [31:0] ack_rdata_i = 32'h00000000;
  logic [31:0] stall = 32'h00000000;
  logic [31:0] mem [0:255];
  logic [23:0] tx_ret_id_o, exp_ret;
  logic [7:0] exp_pp;
  logic exp_wr;
  cfg_msg_pkg::tok_t rx_tok_i, tx_tok_o;
  cfg_msg_pkg::tok_t exp_q[$];
  cfg_msg_pkg::reg_req_t req_o;
  cfg_msg_pkg::space_t exp_sp;
  int failures, cmp_count;
  int pend = 0;
  logic [7:0] ops [0:3] = '{cfg_msg_pkg::TOK_WRITE, cfg_msg_pkg::TOK_READ, cfg_msg_pkg::TOK_PREAD, 8'h55};

  cfg_msg_target u_cfg_msg_target (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .tile_id_i(tile_id_i),
    .node_id_i(node_id_i), .rx_valid_i(rx_valid_i), .rx_tok_i(rx_tok_i), .rx_dest_i(rx_dest_i),
    .rx_ready_o(rx_ready_o), .tx_valid_o(tx_valid_o), .tx_tok_o(tx_tok_o), .tx_ret_id_o(tx_ret_id_o),
    .tx_ready_i(tx_ready_i), .req_valid_o(req_valid_o), .req_o(req_o), .ack_i(ack_i), .ack_ok_i(ack_ok_i),
    .ack_rdata_i(ack_rdata_i));
  reply_sink u_reply_sink (.ref_clk_i(ref_clk_i), .tx_valid_i(tx_valid_o), .tx_tok_i(tx_tok_o),
    .stall_i(stall), .tx_ready_o(tx_ready_i));

  function automatic logic [31:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction

  // Status register resource identifier as an issuer forms it
  function automatic logic [31:0] ps_res_id(input logic [23:0] num);
    return {num, 8'h0b};
  endfunction

  task automatic cmp_tok(input cfg_msg_pkg::tok_t got, input cfg_msg_pkg::tok_t exp);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_req(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    $display("failures=%0d comparisons=%0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Register side: checks each request, acks after 1 to 3 cycles
  // ----------------------------------------------------------------
  always @(negedge ref_clk_i)
  begin
    ack_i <= 1'b0;
    stall <= rnd();
    if (tx_valid_o)
      cmp_req(32'(tx_ret_id_o), 32'(exp_ret));
    if (req_valid_o)
    begin
      cmp_req({req_o.space, req_o.write, req_o.addr}, {exp_sp, exp_wr, exp_addr});
      if (exp_wr)
        cmp_req(req_o.wdata, exp_wd);
      if (exp_sp == cfg_msg_pkg::SP_PERIPH)
        cmp_req(32'(req_o.periph), 32'(exp_pp));
      exp_addr[7:0] = exp_addr[7:0] + 8'h01;
      pend = 1 + cmp_count % 3;
    end
    else if (pend > 0)
    begin
      pend--;
      if (pend == 0)
      begin
        ack_i <= 1'b1;
        ack_ok_i <= req_o.addr[15:8] == 8'h00;
        ack_rdata_i <= mem[req_o.addr[7:0]];
        if (req_o.write && req_o.addr[15:8] == 8'h00)
          mem[req_o.addr[7:0]] = req_o.wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // One message and its reply
  // ----------------------------------------------------------------
  task automatic run_msg(input logic [7:0] op, input cfg_msg_pkg::space_t sp, input logic [23:0] ret,
    input logic [15:0] addr, input logic [31:0] wd, input logic [7:0] sz);
    cfg_msg_pkg::tok_t q[$];
    logic ok;
    int n;
    ok = addr[15:8] == 8'h00;
    exp_sp = sp;
    exp_wr = op == cfg_msg_pkg::TOK_WRITE;
    exp_addr = sp == cfg_msg_pkg::SP_PERIPH ? {8'h00, addr[7:0]} : addr;
    exp_wd = wd;
    exp_ret = ret;
    exp_pp = wd[7:0];
    q.push_back({1'b1, op});
    for (int i = 2; i >= 0; i--) q.push_back({1'b0, ret[8*i +: 8]});
    if (sp == cfg_msg_pkg::SP_PERIPH)
    begin
      q.push_back({1'b0, addr[7:0]});
      q.push_back({1'b0, sz});
      rx_dest_i <= {node_id_i, wd[7:0], cfg_msg_pkg::PERIPH_DEST_LOW};
    end
    else
    begin
      q.push_back({1'b0, addr[15:8]});
      q.push_back({1'b0, addr[7:0]});
      rx_dest_i <= sp == cfg_msg_pkg::SP_TILE ? {tile_id_i, cfg_msg_pkg::TILE_DEST_LOW}
        : {node_id_i, cfg_msg_pkg::NODE_DEST_LOW};
    end
    if (exp_wr)
      for (int i = 3; i >= 0; i--) q.push_back({1'b0, wd[8*i +: 8]});
    q.push_back(9'h101);
    if (op == cfg_msg_pkg::TOK_PREAD && sp == cfg_msg_pkg::SP_PERIPH)
    begin
      exp_q.push_back(9'h103);
      for (int k = 0; k < sz; k++) exp_q.push_back({1'b0, mem[8'(addr[7:0] + k)][7:0]});
    end
    else if (op == cfg_msg_pkg::TOK_READ && ok)
    begin
      exp_q.push_back(9'h103);
      for (int i = 3; i >= 0; i--) exp_q.push_back({1'b0, mem[addr[7:0]][8*i +: 8]});
    end
    else if (!(exp_wr && ret[7:0] == cfg_msg_pkg::NO_REPLY_LOW))
      exp_q.push_back(exp_wr && ok ? 9'h103 : 9'h104);
    if (exp_q.size() > 0)
      exp_q.push_back(9'h101);
    foreach (q[i])
    begin
      rx_tok_i <= q[i];
      rx_valid_i <= 1'b1;
      n = 0;
      while (!rx_ready_o && n < 200)
      begin
        @(negedge ref_clk_i);
        n++;
      end
      @(negedge ref_clk_i);
    end
    rx_valid_i <= 1'b0;
    repeat (3) @(negedge ref_clk_i);
    n = 0;
    while (!(rx_ready_o && u_reply_sink.got.size() >= exp_q.size()) && n < 300)
    begin
      @(negedge ref_clk_i);
      n++;
    end
    cmp_tok(9'(u_reply_sink.got.size()), 9'(exp_q.size()));
    foreach (exp_q[i])
      if (i < u_reply_sink.got.size())
        cmp_tok(u_reply_sink.got[i], exp_q[i]);
    exp_q.delete();
    u_reply_sink.got.delete();
  endtask

  initial
  begin
    ref_clk_i = 1'b0;
    forever #12.5 ref_clk_i = ~ref_clk_i;
  end

  initial
  begin
    #1000000;
    failures++;
    test_done();
  end

  initial
  begin
    logic [31:0] r;
    rng = 32'h0000c559;
    resetn_i = 1'b0;
    rx_valid_i = 1'b0;
    rx_tok_i = '0;
    rx_dest_i = 32'h00000000;
    tile_id_i = 16'(rnd());
    node_id_i = 16'(rnd());
    for (int i = 0; i < 256; i++) mem[i] = rnd();
    repeat (20) @(negedge ref_clk_i);
    resetn_i <= 1'b1;
    repeat (3) @(negedge ref_clk_i);
    run_msg(cfg_msg_pkg::TOK_WRITE, cfg_msg_pkg::SP_TILE, 24'h123400, 16'h0012, 32'ha1b2c3d4, 8'h00);
    run_msg(cfg_msg_pkg::TOK_READ, cfg_msg_pkg::SP_TILE, 24'h123401, 16'h0012, 32'h0, 8'h00);
    run_msg(cfg_msg_pkg::TOK_WRITE, cfg_msg_pkg::SP_NODE, 24'h555502, 16'h0123, 32'h0, 8'h00);
    run_msg(cfg_msg_pkg::TOK_READ, cfg_msg_pkg::SP_NODE, 24'h555503, 16'hff00, 32'h0, 8'h00);
    run_msg(cfg_msg_pkg::TOK_WRITE, cfg_msg_pkg::SP_NODE, 24'h5555ff, 16'h00ff, 32'h0badf00d, 8'h00);
    run_msg(cfg_msg_pkg::TOK_READ, cfg_msg_pkg::SP_NODE, 24'h555504, 16'h00ff, 32'h0, 8'h00);
    run_msg(cfg_msg_pkg::TOK_PREAD, cfg_msg_pkg::SP_PERIPH, 24'h777705, 16'h00fe, 32'h9, 8'h03);
    run_msg(cfg_msg_pkg::TOK_PREAD, cfg_msg_pkg::SP_PERIPH, 24'h777706, 16'h0010, 32'h9, 8'h00);
    run_msg(8'h55, cfg_msg_pkg::SP_TILE, 24'h777707, 16'h0010, 32'h0, 8'h00);
    run_msg(cfg_msg_pkg::TOK_WRITE, cfg_msg_pkg::SP_TILE, 24'h123408, 16'h0013, ps_res_id(24'h000005), 8'h00);
    run_msg(cfg_msg_pkg::TOK_READ, cfg_msg_pkg::SP_TILE, 24'h123409, 16'h0013, 32'h0, 8'h00);
    for (int m = 0; m < 40; m++)
    begin
      r = rnd();
      run_msg(ops[r[1:0]], r[1:0] == 2'h2 ? cfg_msg_pkg::SP_PERIPH : r[3] ? cfg_msg_pkg::SP_NODE
        : cfg_msg_pkg::SP_TILE, {r[31:16], r[6] ? 8'hff : r[15:8]}, {7'h00, r[4] & r[5], r[15:8]},
        16'(rnd()), {6'h00, r[25:24]});
    end
    test_done();
  end
endmodule
